// ===== core/mtt_pkg.sv
// Package of register map, field layout and constants for the MMU translation block
package mtt_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0]
    A_OSC = 8'h00,
    A_MCNTL = 8'h04,
    A_TBX = 8'h08,
    A_TBL = 8'h0C,
    A_TBEFF = 8'h10,
    A_TBCNT = 8'h14,
    A_DCU_HI = 8'h18,
    A_DCU_LO = 8'h1C,
    A_DTAG = 8'h20,
    A_DLO = 8'h24,
    A_DHI = 8'h28,
    A_DGO = 8'h2C,
    A_ACC = 8'h30,
    A_ALO = 8'h34,
    A_AHI = 8'h38,
    A_ATAG = 8'h3C,
    A_DFA_LO = 8'h40,
    A_DFA_HI = 8'h44,
    A_DFS = 8'h48,
    A_IST = 8'h50,
    A_IMSK = 8'h54;

  // Control bit positions
  localparam int
    OSC_PA43 = 0,
    MC_LEGACY = 0,
    MC_SPLIT = 1,
    DGO_INSTR = 0,
    DCU_WSPEC = 41;
  localparam int DCU_WSPEC_HI = DCU_WSPEC - 32;

  // Translation table register layout
  localparam int
    TS_SIZE_LSB = 0,
    TS_SIZE_W = 4;
  localparam logic [31:0]
    TS_KEEP = 32'hFFFF_E00F,
    TS_UNIT = 32'h0000_0200;

  // Translation entry layout
  localparam int
    TE_SZ_LSB = 0,
    TE_SZ_MSB = 1,
    TE_LOCK = 6,
    TE_PA_LSB = 13,
    TE_PA_MSB = 42,
    TE_PA41_MSB = 40,
    TE_RSV_LSB = 43,
    TE_RSV_MSB = 46,
    PA_W = 43,
    VPN_LSB = 13,
    VPN_W = 32;

  // Data-access address decode
  localparam int
    ACC_ALIAS_MSB = 17,
    ACC_IDX_LSB = 3,
    ACC_FA_BIT = 12,
    ACC_SEL_I = 16;

  // Interrupt status bits
  localparam int
    IRQ_FAULT = 0,
    IRQ_MISS = 1,
    IRQ_SUPP = 2,
    IRQ_W = 3,
    DFS_W = 16;

endpackage

// ===== core/mtt_tlb_if.sv
// Interface between the MMU control logic and one TLB pair
`timescale 1ns/1ps
interface mtt_tlb_if #(
  parameter int IDX_W = 3
);
  // Entry store from the data-in registers
  logic wr_req;
  logic [31:0] wr_vpn;
  logic [63:0] wr_data;
  // Diagnostic entry read
  logic rd_fa;
  logic [IDX_W-1:0] rd_idx;
  logic [63:0] rd_data;
  logic [31:0] rd_tag;
  // Pipeline lookup
  logic lk_req;
  logic [31:0] lk_vpn;
  logic lk_hit;
  logic [63:0] lk_data;

  modport ctrl (output wr_req, wr_vpn, wr_data, rd_fa, rd_idx, lk_req, lk_vpn,
                input rd_data, rd_tag, lk_hit, lk_data);
  modport tlb (input wr_req, wr_vpn, wr_data, rd_fa, rd_idx, lk_req, lk_vpn,
               output rd_data, rd_tag, lk_hit, lk_data);
endinterface // mtt_tlb_if

// ===== core/mtt_tlb.sv
// One TLB pair: fully associative part with pseudo-LRU, two-way set-associative part with LRU
`timescale 1ns/1ps
module mtt_tlb import mtt_pkg::*; #(
  parameter int FA_N = 8,
  parameter int SA_SETS = 4
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control side
  mtt_tlb_if.tlb t
);
  localparam int FA_W = $clog2(FA_N);
  localparam int SET_W = $clog2(SA_SETS);

  logic [63:0] fa_data [FA_N];
  logic [31:0] fa_tag [FA_N];
  logic [FA_N-1:0] fa_vld;
  logic [FA_N-2:0] plru;
  logic [63:0] sa_data [SA_SETS][2];
  logic [31:0] sa_tag [SA_SETS][2];
  logic [1:0] sa_vld [SA_SETS];
  logic [SA_SETS-1:0] sa_lru;

  logic to_fa;
  logic [FA_W-1:0] fa_vict;
  logic [63:0] store;
  logic [SET_W-1:0] wr_set;
  logic [SET_W-1:0] lk_set;
  logic fa_hit;
  logic [FA_W-1:0] fa_hit_idx;
  logic [1:0] sa_hit;
  logic [SET_W-1:0] rd_set;

  ////////////////////////////////////////////////////////////////////////
  // Pseudo-LRU tree walk, heap-ordered nodes
  function automatic logic [FA_W-1:0] plru_victim(input logic [FA_N-2:0] tr);
    int n;
    n = 0;
    for (int l = 0; l < FA_W; l++) begin
      n = 2 * n + 1 + int'(tr[n]);
    end
    return FA_W'(n - (FA_N - 1));
  endfunction

  // Point every node on the path away from the touched leaf
  function automatic logic [FA_N-2:0] plru_touch(input logic [FA_N-2:0] tr, input logic [FA_W-1:0] idx);
    int n;
    logic [FA_N-2:0] r;
    n = 0;
    r = tr;
    for (int l = 0; l < FA_W; l++) begin
      r[n] = ~idx[FA_W-1-l];
      n = 2 * n + 1 + int'(idx[FA_W-1-l]);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // lock or page size steers
  always_comb begin
    to_fa = t.wr_data[TE_LOCK] | (|t.wr_data[TE_SZ_MSB:TE_SZ_LSB]);
    wr_set = t.wr_vpn[SET_W-1:0];
    lk_set = t.lk_vpn[SET_W-1:0];
    rd_set = t.rd_idx[SET_W:1];
    store = t.wr_data;
    store[TE_RSV_MSB:TE_RSV_LSB] = '0;
  end

  always_comb begin
    fa_vict = plru_victim(plru);
    if (fa_vld[fa_vict] && fa_data[fa_vict][TE_LOCK]) begin
      for (int i = FA_N - 1; i >= 0; i--) begin
        if (!(fa_vld[i] && fa_data[i][TE_LOCK])) begin
          fa_vict = FA_W'(i);
        end
      end
    end
  end

  // Associative match for the pipeline lookup
  always_comb begin
    fa_hit = 1'b0;
    fa_hit_idx = '0;
    for (int i = 0; i < FA_N; i++) begin
      if (fa_vld[i] && fa_tag[i] == t.lk_vpn) begin
        fa_hit = 1'b1;
        fa_hit_idx = FA_W'(i);
      end
    end
    for (int w = 0; w < 2; w++) begin
      sa_hit[w] = sa_vld[lk_set][w] && sa_tag[lk_set][w] == t.lk_vpn;
    end
    t.lk_hit = fa_hit | (|sa_hit);
    t.lk_data = fa_hit ? fa_data[fa_hit_idx] : sa_data[lk_set][sa_hit[1]];
  end

  // Diagnostic read of one entry
  always_comb begin
    t.rd_data = t.rd_fa ? fa_data[t.rd_idx] : sa_data[rd_set][t.rd_idx[0]];
    t.rd_tag = t.rd_fa ? fa_tag[t.rd_idx] : sa_tag[rd_set][t.rd_idx[0]];
  end

  ////////////////////////////////////////////////////////////////////////
  // Entry storage; no reset, valid bits guard it
  always_ff @(posedge clk_i) begin
    if (ce_i && t.wr_req) begin
      if (to_fa) begin
        fa_data[fa_vict] <= store;
        fa_tag[fa_vict] <= t.wr_vpn;
      end else begin
        sa_data[wr_set][sa_lru[wr_set]] <= {store[63:TE_LOCK+1], 1'b0, store[TE_LOCK-1:0]};
        sa_tag[wr_set][sa_lru[wr_set]] <= t.wr_vpn;
      end
    end
  end

  // Valid bits and replacement state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fa_vld <= '0;
      plru <= '0;
      sa_lru <= '0;
      for (int s = 0; s < SA_SETS; s++) begin
        sa_vld[s] <= 2'h0;
      end
    end else if (ce_i) begin
      if (t.wr_req) begin
        if (to_fa) begin
          fa_vld[fa_vict] <= 1'b1;
          plru <= plru_touch(plru, fa_vict);
        end else begin
          sa_vld[wr_set][sa_lru[wr_set]] <= 1'b1;
          sa_lru[wr_set] <= ~sa_lru[wr_set];
        end
      end else if (t.lk_req) begin
        if (fa_hit) begin
          plru <= plru_touch(plru, fa_hit_idx);
        end else if (|sa_hit) begin
          sa_lru[lk_set] <= ~sa_hit[1];
        end
      end
    end
  end

endmodule // mtt_tlb

// ===== core/mtt_mmu.sv
// MMU translation control: table base, address width, TLB access, fault capture, Wishbone registers
// Functional notes
// - table size is four bits at 3:0
// - up to 16M entries, 32M when split
// - base from extension register unless legacy flag clear
// - 41-bit or 43-bit physical address mode
// - pseudo-LRU in full, true LRU in set
// - set-associative lock bit reads zero, writes dropped
// - page-offset bits of entry writes preserved
// - access address bits above 17 ignored, aliasing
// - JMPL/RETURN misalignment leaves fault registers alone
// - fault address upper thirty-two bits load zero
// - cacheable physical/virtual bits not implemented
// - bit 41 is weak speculation enable
// - entry bits 46:43 read zero, writes ignored
// - locked entries go to full TLB, else size
`timescale 1ns/1ps
module mtt_mmu import mtt_pkg::*; #(
  parameter int FA_N = 8,
  parameter int SA_SETS = 4,
  parameter logic PA43_AT_RESET = 1'b1
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pipeline lookup
  input wire logic lk_req_i,
  input wire logic lk_instr_i,
  input wire logic [63:0] lk_va_i,
  output logic lk_done_o,
  output logic lk_hit_o,
  output logic [PA_W-1:0] lk_pa_o,
  // Pipeline data fault report
  input wire logic flt_req_i,
  input wire logic flt_misalign_jmpl_i,
  input wire logic [63:0] flt_addr_i,
  input wire logic [DFS_W-1:0] flt_status_i,
  // Configuration seen by the core
  output logic [31:0] translation_table_base_o,
  output logic [TS_SIZE_W-1:0] translation_table_size_o,
  output logic weak_speculation_enable_o,
  output logic pa43_mode_o,
  // Interrupt
  output logic irq_o
);
  localparam int IDX_W = $clog2(FA_N);

  // Software-visible state
  logic osc_pa43;
  logic legacy_base_select;
  logic split_table;
  logic [31:0] tb_ext;
  logic [31:0] tb_legacy;
  logic weak_spec;
  logic [31:0] din_tag;
  logic [31:0] din_lo;
  logic [31:0] din_hi;
  logic [31:0] acc_addr;
  logic [31:0] dfa;
  logic [DFS_W-1:0] dfs;
  logic [IRQ_W-1:0] ist;
  logic [IRQ_W-1:0] imsk;

  // Bus decode
  logic acc;
  logic wr;
  logic [31:0] rd_mux;
  logic [31:0] tb_eff;
  logic [31:0] tb_count;
  logic [17:0] acc_eff;
  logic [63:0] acc_data;
  logic [31:0] acc_tag;
  logic [IRQ_W-1:0] next_ist;
  logic [IRQ_W-1:0] ev;
  logic lk_hit;
  logic [63:0] lk_data;

  mtt_tlb_if #(.IDX_W(IDX_W)) itlb_if();
  mtt_tlb_if #(.IDX_W(IDX_W)) dtlb_if();

  ////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Ack one cycle late; writes land at the edge where the master sees ack
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // legacy flag clear picks legacy base
  assign tb_eff = legacy_base_select ? tb_ext : tb_legacy;
  // 512 times two to the size, doubled when split
  assign tb_count = (TS_UNIT << tb_eff[TS_SIZE_LSB +: TS_SIZE_W]) << split_table;
  assign acc_eff = acc_addr[ACC_ALIAS_MSB:0];
  assign acc_data = acc_eff[ACC_SEL_I] ? itlb_if.rd_data : dtlb_if.rd_data;
  assign acc_tag = acc_eff[ACC_SEL_I] ? itlb_if.rd_tag : dtlb_if.rd_tag;

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_adr_i)
      A_OSC: rd_mux[OSC_PA43] = osc_pa43;
      A_MCNTL: rd_mux = {30'h0, split_table, legacy_base_select};
      A_TBX: rd_mux = tb_ext;
      A_TBL: rd_mux = tb_legacy;
      A_TBEFF: rd_mux = tb_eff;
      A_TBCNT: rd_mux = tb_count;
      A_DCU_HI: rd_mux[DCU_WSPEC_HI] = weak_spec;
      A_DCU_LO: rd_mux = 32'h0;
      A_DTAG: rd_mux = din_tag;
      A_DLO: rd_mux = din_lo;
      A_DHI: rd_mux = din_hi;
      A_ACC: rd_mux = acc_addr;
      A_ALO: rd_mux = acc_data[31:0];
      A_AHI: rd_mux = acc_data[63:32];
      A_ATAG: rd_mux = acc_tag;
      A_DFA_LO: rd_mux = dfa;
      A_DFA_HI: rd_mux = 32'h0;
      A_DFS: rd_mux[DFS_W-1:0] = dfs;
      A_IST: rd_mux[IRQ_W-1:0] = ist;
      A_IMSK: rd_mux[IRQ_W-1:0] = imsk;
      default: rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode and control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_pa43 <= PA43_AT_RESET;
      legacy_base_select <= 1'b1;
      split_table <= 1'b0;
      weak_spec <= 1'b0;
      imsk <= '0;
    end else if (ce_i && wr) begin
      if (wb_adr_i == A_OSC && wb_sel_i[0]) begin
        osc_pa43 <= wb_dat_i[OSC_PA43];
      end
      if (wb_adr_i == A_MCNTL && wb_sel_i[0]) begin
        legacy_base_select <= wb_dat_i[MC_LEGACY];
        split_table <= wb_dat_i[MC_SPLIT];
      end
      if (wb_adr_i == A_DCU_HI && wb_sel_i[1]) begin
        weak_spec <= wb_dat_i[DCU_WSPEC_HI];
      end
      if (wb_adr_i == A_IMSK && wb_sel_i[0]) begin
        imsk <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_ext <= 32'h0;
      tb_legacy <= 32'h0;
    end else if (ce_i && wr) begin
      if (wb_adr_i == A_TBX) begin
        tb_ext <= merge(tb_ext, wb_dat_i, wb_sel_i) & TS_KEEP;
      end
      if (wb_adr_i == A_TBL) begin
        tb_legacy <= merge(tb_legacy, wb_dat_i, wb_sel_i) & TS_KEEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data-in staging and access address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_tag <= 32'h0;
      din_lo <= 32'h0;
      din_hi <= 32'h0;
      acc_addr <= 32'h0;
    end else if (ce_i && wr) begin
      if (wb_adr_i == A_DTAG) begin
        din_tag <= merge(din_tag, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == A_DLO) begin
        din_lo <= merge(din_lo, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == A_DHI) begin
        din_hi <= merge(din_hi, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == A_ACC) begin
        acc_addr <= merge(acc_addr, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Store pulse one cycle after the go write, staged data already settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      itlb_if.wr_req <= 1'b0;
      dtlb_if.wr_req <= 1'b0;
    end else if (ce_i) begin
      itlb_if.wr_req <= wr && wb_adr_i == A_DGO && wb_sel_i[0] && wb_dat_i[DGO_INSTR];
      dtlb_if.wr_req <= wr && wb_adr_i == A_DGO && wb_sel_i[0] && !wb_dat_i[DGO_INSTR];
    end
  end

  // Shared request wiring to both TLB pairs
  always_comb begin
    itlb_if.wr_vpn = din_tag;
    itlb_if.wr_data = {din_hi, din_lo};
    itlb_if.rd_fa = acc_eff[ACC_FA_BIT];
    itlb_if.rd_idx = acc_eff[ACC_IDX_LSB +: IDX_W];
    itlb_if.lk_req = lk_req_i & lk_instr_i;
    itlb_if.lk_vpn = lk_va_i[VPN_LSB +: VPN_W];
    dtlb_if.wr_vpn = din_tag;
    dtlb_if.wr_data = {din_hi, din_lo};
    dtlb_if.rd_fa = acc_eff[ACC_FA_BIT];
    dtlb_if.rd_idx = acc_eff[ACC_IDX_LSB +: IDX_W];
    dtlb_if.lk_req = lk_req_i & ~lk_instr_i;
    dtlb_if.lk_vpn = lk_va_i[VPN_LSB +: VPN_W];
  end

  mtt_tlb #(.FA_N(FA_N), .SA_SETS(SA_SETS)) u_itlb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .t(itlb_if)
  );

  mtt_tlb #(.FA_N(FA_N), .SA_SETS(SA_SETS)) u_dtlb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .t(dtlb_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // Lookup answer, registered one cycle after the request
  assign lk_hit = lk_instr_i ? itlb_if.lk_hit : dtlb_if.lk_hit;
  assign lk_data = lk_instr_i ? itlb_if.lk_data : dtlb_if.lk_data;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk_done_o <= 1'b0;
      lk_hit_o <= 1'b0;
      lk_pa_o <= '0;
    end else if (ce_i) begin
      lk_done_o <= lk_req_i;
      lk_hit_o <= lk_req_i & lk_hit;
      if (lk_req_i && lk_hit) begin
        lk_pa_o <= {lk_data[TE_PA_MSB:TE_PA_LSB], lk_va_i[VPN_LSB-1:0]};
        // narrow mode clears the top two bits
        if (!osc_pa43) begin
          lk_pa_o[TE_PA_MSB:TE_PA41_MSB+1] <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dfa <= 32'h0;
      dfs <= '0;
    end else if (ce_i) begin
      if (flt_req_i && !flt_misalign_jmpl_i) begin
        dfa <= flt_addr_i[31:0];
        dfs <= flt_status_i;
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    ev = '0;
    ev[IRQ_FAULT] = flt_req_i & ~flt_misalign_jmpl_i;
    ev[IRQ_SUPP] = flt_req_i & flt_misalign_jmpl_i;
    ev[IRQ_MISS] = lk_req_i & ~lk_hit;
    next_ist = ist;
    if (wr && wb_adr_i == A_IST && wb_sel_i[0]) begin
      next_ist = ist & ~wb_dat_i[IRQ_W-1:0];
    end
    next_ist = next_ist | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      ist <= next_ist;
      irq_o <= |(next_ist & imsk);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  assign translation_table_base_o = {tb_eff[31:TS_SIZE_W], TS_SIZE_W'(0)} & TS_KEEP;
  assign translation_table_size_o = tb_eff[TS_SIZE_LSB +: TS_SIZE_W];
  assign weak_speculation_enable_o = weak_spec;
  assign pa43_mode_o = osc_pa43;

endmodule // mtt_mmu

// ===== verif/mtt_mmu_props.sv
// Assertions on bus, lookup and configuration outputs of the MMU block
`timescale 1ns/1ps
module mtt_mmu_props import mtt_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Lookup
  input wire logic lk_req_i,
  input wire logic lk_done_o,
  input wire logic lk_hit_o,
  input wire logic [PA_W-1:0] lk_pa_o,
  // Configuration
  input wire logic [31:0] translation_table_base_o,
  input wire logic [TS_SIZE_W-1:0] translation_table_size_o,
  input wire logic weak_speculation_enable_o,
  input wire logic pa43_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req, take, leg_sel;
  logic [31:0] ext_tab, leg_tab, sel_tab;
  // Requests are taken while ack is low; writes land at the ack edge
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  assign take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & ce_i;
  assign sel_tab = leg_sel ? ext_tab : leg_tab;
  // Shadow of table registers, full-word writes only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_tab <= 32'h0;
      leg_tab <= 32'h0;
      leg_sel <= 1'b1;
    end else if (take && wb_sel_i == 4'hF) begin
      if (wb_adr_i == A_TBX) ext_tab <= wb_dat_i & TS_KEEP;
      if (wb_adr_i == A_TBL) leg_tab <= wb_dat_i & TS_KEEP;
      if (wb_adr_i == A_MCNTL) leg_sel <= wb_dat_i[MC_LEGACY];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ack_latency: assert property (req |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_lookup_done: assert property (lk_req_i && ce_i |=> lk_done_o)
    else $error("no lookup answer");
  a_hit_with_done: assert property (lk_hit_o |-> lk_done_o)
    else $error("hit without done");
  a_pa_narrow: assert property (lk_hit_o && !pa43_mode_o |-> lk_pa_o[42:41] == 2'b00)
    else $error("upper address bits set");
  a_pa_mode_write: assert property (take && wb_adr_i == A_OSC && wb_sel_i[0]
    |=> pa43_mode_o == $past(wb_dat_i[OSC_PA43]))
    else $error("width mode not written");
  a_wspec_write: assert property (take && wb_adr_i == A_DCU_HI && wb_sel_i[1]
    |=> weak_speculation_enable_o == $past(wb_dat_i[DCU_WSPEC_HI]))
    else $error("speculation bit not written");
  a_base_select: assert property (!take && !$past(take)
    |-> translation_table_base_o == (sel_tab & 32'hFFFF_E000))
    else $error("wrong table base");
  a_size_field: assert property (!take && !$past(take)
    |-> translation_table_size_o == sel_tab[3:0])
    else $error("wrong table size");
  // Main scenarios reached
  c_mode_switch: cover property (take && wb_adr_i == A_MCNTL);
  c_hit: cover property (lk_hit_o);
  c_miss: cover property (lk_done_o && !lk_hit_o);
endmodule // mtt_mmu_props

bind mtt_mmu mtt_mmu_props u_props (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .lk_req_i, .lk_done_o, .lk_hit_o, .lk_pa_o, .translation_table_base_o,
  .translation_table_size_o, .weak_speculation_enable_o, .pa43_mode_o);

// ===== verif/mtt_pipe_model.sv
// Model of the load/store and fetch pipeline issuing lookups and fault reports
`timescale 1ns/1ps
module mtt_pipe_model import mtt_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Lookup requests
  output logic lk_req_o,
  output logic lk_instr_o,
  output logic [63:0] lk_va_o,
  // Fault reports
  output logic flt_req_o,
  output logic flt_misalign_jmpl_o,
  output logic [63:0] flt_addr_o,
  output logic [DFS_W-1:0] flt_status_o
);
  // Idle at time zero
  initial begin
    {lk_req_o, lk_instr_o, lk_va_o, flt_req_o, flt_misalign_jmpl_o, flt_addr_o, flt_status_o} = '0;
  end
  // One-cycle lookup; address inverted on release
  task automatic lookup(input logic instr, input logic [63:0] va);
    @(posedge clk_i);
    lk_req_o <= 1'b1;
    lk_instr_o <= instr;
    lk_va_o <= va;
    @(posedge clk_i);
    lk_req_o <= 1'b0;
    lk_va_o <= ~va;
  endtask
  // One-cycle fault report
  task automatic fault(input logic jmpl, input logic [63:0] a, input logic [DFS_W-1:0] st);
    @(posedge clk_i);
    flt_req_o <= 1'b1;
    flt_misalign_jmpl_o <= jmpl;
    flt_addr_o <= a;
    flt_status_o <= st;
    @(posedge clk_i);
    flt_req_o <= 1'b0;
    flt_addr_o <= ~a;
    flt_status_o <= ~st;
  endtask
endmodule // mtt_pipe_model

// ===== verif/tb_mtt_mmu.sv
// Self-checking testbench of the MMU translation block
`timescale 1ns/1ps
module tb_mtt_mmu import mtt_pkg::*; ;
  localparam logic [63:0] E1 = 64'h0000_0401_2345_6000;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, lk_req, lk_instr, lk_done_o, lk_hit_o, flt_req, flt_jmpl, wspec, pa43, irq_o;
  logic [63:0] lk_va, flt_addr;
  logic [DFS_W-1:0] flt_st;
  logic [PA_W-1:0] lk_pa_o;
  logic [31:0] base;
  logic [TS_SIZE_W-1:0] size;
  int n_errors = 0, comparisons = 0, cycles = 0;
  always #20 clk_i = ~clk_i;
  mtt_mmu DUT (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .lk_req_i(lk_req), .lk_instr_i(lk_instr), .lk_va_i(lk_va), .lk_done_o, .lk_hit_o, .lk_pa_o,
    .flt_req_i(flt_req), .flt_misalign_jmpl_i(flt_jmpl), .flt_addr_i(flt_addr), .flt_status_i(flt_st),
    .translation_table_base_o(base), .translation_table_size_o(size), .weak_speculation_enable_o(wspec),
    .pa43_mode_o(pa43), .irq_o);
  mtt_pipe_model pipe (.clk_i, .lk_req_o(lk_req), .lk_instr_o(lk_instr), .lk_va_o(lk_va),
    .flt_req_o(flt_req), .flt_misalign_jmpl_o(flt_jmpl), .flt_addr_o(flt_addr), .flt_status_o(flt_st));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far above the run's length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check(n < 40, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // Entry store lands one edge after the trigger write
  task automatic store(input logic instr, input logic [31:0] vpn, input logic [63:0] e);
    wr(A_DTAG, vpn);
    wr(A_DLO, e[31:0]);
    wr(A_DHI, e[63:32]);
    wr(A_DGO, {31'h0, instr});
    @(posedge clk_i);
  endtask
  // Scan one TLB part for a tag; idx stays -1 when absent
  task automatic find(input logic instr, input logic fa, input logic [31:0] vpn, output int idx,
                      output logic [63:0] e);
    logic [31:0] q;
    idx = -1;
    e = '0;
    for (int i = 0; i < 8; i++) begin
      wr(A_ACC, {15'h0, instr, 3'h0, fa, 6'h0, 3'(i), 3'h0});
      rd(A_ATAG, q);
      if (q === vpn && idx < 0) begin
        idx = i;
        rd(A_ALO, e[31:0]);
        rd(A_AHI, e[63:32]);
      end
    end
  endtask
  task automatic look(input logic instr, input logic [31:0] vpn, output logic hit, output logic [PA_W-1:0] pa);
    pipe.lookup(instr, {19'h0, vpn, 13'h0ABC});
    @(negedge clk_i);
    check(lk_done_o, 1'b1);
    hit = lk_hit_o;
    pa = lk_pa_o;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    check(pa43, 1'b1);
    rdc(A_MCNTL, 32'h1);
    rdc(A_DFA_HI, 32'h0);
    rdc(8'h4C, 32'h0);
    check(irq_o, 1'b0);
  endtask
  task automatic s_table();
    wr(A_TBX, 32'h1234_5FFF);
    wr(A_TBL, 32'h0ABC_E003);
    @(negedge clk_i);
    check(base, 32'h1234_4000);
    check(size, 4'hF);
    rdc(A_TBCNT, 32'h0100_0000);
    wr(A_MCNTL, 32'h0);
    @(negedge clk_i);
    check(base, 32'h0ABC_E000);
    check(size, 4'h3);
    rdc(A_TBCNT, 32'h0000_1000);
    wr(A_MCNTL, 32'h2);
    wr(A_TBL, 32'h0000_000F);
    rdc(A_TBCNT, 32'h0200_0000);
    wr(A_MCNTL, 32'h1);
  endtask
  // Small entry, both address widths, then a large page
  task automatic s_entry();
    logic hit;
    logic [PA_W-1:0] pa;
    int idx;
    logic [63:0] e;
    store(1'b0, 32'h10, 64'h0000_7C01_2345_6000);
    find(1'b0, 1'b0, 32'h10, idx, e);
    check(e, E1);
    check(e[TE_LOCK], 1'b0);
    look(1'b0, 32'h10, hit, pa);
    check(pa, {E1[42:13], 13'h0ABC});
    wr(A_OSC, 32'h0);
    look(1'b0, 32'h10, hit, pa);
    check(pa, {2'b00, E1[40:13], 13'h0ABC});
    wr(A_OSC, 32'h1);
    store(1'b1, 32'h33, 64'h0000_0000_0AB3_E0A3);
    find(1'b1, 1'b1, 32'h33, idx, e);
    check(e, 64'h0000_0000_0AB3_E0A3);
  endtask
  // Locked small entry goes to the full part; read again through an alias
  task automatic s_lock();
    int idx;
    logic [63:0] e;
    logic [31:0] q;
    store(1'b1, 32'h21, 64'h0000_0000_0004_2040);
    find(1'b1, 1'b0, 32'h21, idx, e);
    check(idx < 0, 1'b1);
    find(1'b1, 1'b1, 32'h21, idx, e);
    check(e[TE_LOCK], 1'b1);
    wr(A_ACC, {1'b1, 12'h0, 1'b1, 1'b0, 1'b1, 3'h0, 1'b1, 6'h0, 3'(idx), 3'h0});
    rd(A_ALO, q);
    check(q, 32'h0004_2040);
  endtask
  // Two ways of one set: the one not used last is evicted
  task automatic s_lru();
    logic hit;
    logic [PA_W-1:0] pa;
    store(1'b0, 32'h14, E1);
    look(1'b0, 32'h10, hit, pa);
    store(1'b0, 32'h18, E1);
    look(1'b0, 32'h14, hit, pa);
    check(hit, 1'b0);
    look(1'b0, 32'h10, hit, pa);
    check(hit, 1'b1);
    look(1'b0, 32'h18, hit, pa);
    check(hit, 1'b1);
  endtask
  task automatic s_fault();
    wr(A_IST, 32'h7);
    wr(A_IMSK, 32'h1);
    pipe.fault(1'b0, 64'hFFFF_FFFF_8000_1234, 16'h00A5);
    repeat (2) @(negedge clk_i);
    check(irq_o, 1'b1);
    rdc(A_DFA_LO, 32'h8000_1234);
    rdc(A_DFA_HI, 32'h0);
    rdc(A_DFS, 32'h0000_00A5);
    wr(A_IST, 32'h1);
    repeat (2) @(negedge clk_i);
    check(irq_o, 1'b0);
    pipe.fault(1'b1, 64'h0000_0000_0000_0F0F, 16'h0033);
    rdc(A_DFA_LO, 32'h8000_1234);
    rdc(A_DFS, 32'h0000_00A5);
    rdc(A_IST, 32'h4);
    check(irq_o, 1'b0);
    wr(A_IMSK, 32'h4);
    repeat (2) @(negedge clk_i);
    check(irq_o, 1'b1);
  endtask
  task automatic s_cache_ctl();
    wr(A_DCU_HI, 32'h0000_0200);
    @(negedge clk_i);
    check(wspec, 1'b1);
    wr(A_DCU_LO, 32'hFFFF_FFFF);
    rdc(A_DCU_LO, 32'h0);
    wr(A_DCU_HI, 32'h0);
    @(negedge clk_i);
    check(wspec, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_table();
    s_entry();
    s_lock();
    s_lru();
    s_fault();
    s_cache_ctl();
    wrap_up();
  end
endmodule // tb_mtt_mmu
